/* File: dtc_timer_top.sv */
// dual timer/counter with four modes, apb register access
// assumes pins are synchronous to pclk and a single clock domain
`include "dtc_consts.svh"

// Summary of operation
// [R1] timer counts machine cycles, six clocks each
// [R2] counter counts sampled high-to-low pin transitions
// [R3] edge increment shows one machine cycle later
// [R4] count pin holds each level one cycle
// [R5] function and mode chosen per timer
// [R6] count only when run and gate allow, except b ignores its run bit while a is split and split high has no gate
// [R7] mode 0 is thirteen bit counter
// [R8] wrap to zero sets overflow flag
// [R9] setting run leaves count unchanged
// [R10] each timer has its own gate bit
// [R11] mode 1 uses all sixteen bits
// [R12] mode 2 reloads low from high
// [R13] timer b in mode 3 stops
// [R14] split low byte uses timer a controls
// [R15] split high byte uses timer b run, flag
// [R16] timer b still runs for baud
// [R17] overflow toggles count pin when enabled
// [R18] toggle enable per timer, starts high
// [R19] compat bit makes machine cycle twelve clocks
// [R20] flag holds until cleared or acknowledged
module dtc_timer_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // count pins, also used as toggle outputs
    input wire logic count_pin_a,
    output logic count_pin_a_drv,
    output logic count_pin_a_oe,
    input wire logic count_pin_b,
    output logic count_pin_b_drv,
    output logic count_pin_b_oe,
    // gate pins, high lets a gated timer count
    input wire logic gate_pin_a,
    input wire logic gate_pin_b,
    // interrupt system acknowledge pulses
    input wire logic irq_ack_a,
    input wire logic irq_ack_b,
    // flags and baud source towards the rest of the chip
    output logic overflow_flag_a,
    output logic overflow_flag_b,
    output logic baud_tick
);

    // every check below runs on pclk and sleeps through reset
    default clocking dtc_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // register state
    logic [7:0] tmode_r; // timer mode register
    logic run_bit_a_r; // run bit of timer a
    logic run_bit_b_r; // run bit of timer b
    logic flag_a_r; // overflow flag a
    logic flag_b_r; // overflow flag b
    logic [7:0] low_a_r; // low byte a
    logic [7:0] high_a_r; // high byte a
    logic [7:0] low_b_r; // low byte b
    logic [7:0] high_b_r; // high byte b
    logic tog_en_a_r; // toggle enable a
    logic tog_en_b_r; // toggle enable b
    logic halve_r; // compat clock halve as written
    logic halve_eff_r; // halve in force for the current machine cycle
    logic tog_a_r; // toggle level a
    logic tog_b_r; // toggle level b
    logic baud_r; // timer b overflow pulse
    // machine cycle divider
    logic [3:0] div_r;
    logic tick_r;
    // apb answer
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // decoded fields
    dtc_pkg::dtc_tsel_t sel_a;
    dtc_pkg::dtc_tsel_t sel_b;
    logic split_a; // timer a in split mode
    logic fall_a; // edge pending on count pin a
    logic fall_b; // edge pending on count pin b
    logic inc_a; // low/whole timer a advances
    logic inc_b; // timer b advances
    logic inc_ha; // split high byte advances
    logic [8:0] ha_sum; // split high byte plus one
    dtc_pkg::dtc_step_t step_a;
    dtc_pkg::dtc_step_t step_b;
    logic ovf_a; // timer a (or split low) overflow
    logic ovf_b; // timer b overflow
    logic set_fa; // event for flag a
    logic set_fb; // event for flag b
    logic [7:0] ctl_view; // control register as read
    // apb decode
    logic setup;
    logic acc_wr;
    logic wr_tmode;
    logic wr_ctl;
    logic wr_low_a;
    logic wr_high_a;
    logic wr_low_b;
    logic wr_high_b;
    logic wr_pmode;
    logic wr_cfg;

    // one counting step of one timer in its mode
    function automatic dtc_pkg::dtc_step_t step_f(
        input dtc_pkg::dtc_mode_t mode,
        input logic [7:0] lo,
        input logic [7:0] hi,
        input logic inc
    );
        dtc_pkg::dtc_step_t s;
        logic [13:0] sum13;
        logic [16:0] sum16;
        logic [8:0] sum8;
        s.lo = lo;
        s.hi = hi;
        s.ovf = 1'b0;
        sum13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        sum16 = {1'b0, hi, lo} + 17'h00001;
        sum8 = {1'b0, lo} + 9'h001;
        if (inc)
        begin
            case (mode)
                dtc_pkg::DTC_MODE_13:
                begin
                    // top three low bits are left as they are
                    s.hi = sum13[12:5]; // [R7]
                    s.lo = {lo[7:5], sum13[4:0]}; // [R7]
                    s.ovf = sum13[13]; // [R8]
                end
                dtc_pkg::DTC_MODE_16:
                begin
                    s.hi = sum16[15:8]; // [R11]
                    s.lo = sum16[7:0]; // [R11]
                    s.ovf = sum16[16]; // [R8]
                end
                dtc_pkg::DTC_MODE_RELOAD:
                begin
                    // high byte is the reload value and never moves
                    s.lo = sum8[8] ? hi : sum8[7:0]; // [R12]
                    s.ovf = sum8[8]; // [R12]
                end
                dtc_pkg::DTC_MODE_SPLIT:
                begin
                    s.lo = sum8[7:0]; // [R14]
                    s.ovf = sum8[8]; // [R14]
                end
                default:
                begin
                    s.ovf = 1'b0;
                end
            endcase
        end
        return s;
    endfunction

    // field decode of the mode register, one gate bit per timer
    assign sel_a = dtc_pkg::dtc_tsel_t'(
        tmode_r[`DTC_TMODE_A_MSB:`DTC_TMODE_A_LSB]); // [R5] [R10]
    assign sel_b = dtc_pkg::dtc_tsel_t'(
        tmode_r[`DTC_TMODE_B_MSB:`DTC_TMODE_B_LSB]); // [R5] [R10]
    assign split_a = sel_a.mode == dtc_pkg::DTC_MODE_SPLIT;

    // edge samplers for the two count pins
    dtc_pin_sampler u_smp_a (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_r),
        .pin(count_pin_a),
        .fall(fall_a)
    );
    dtc_pin_sampler u_smp_b (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_r),
        .pin(count_pin_b),
        .fall(fall_b)
    );

    // count enables; a fall is applied at the tick after it was seen
    assign inc_a = tick_r & run_bit_a_r & (~sel_a.gate | gate_pin_a)
        & (sel_a.ct ? fall_a : 1'b1); // [R1] [R3] [R6] [R14]
    // while a is split, b ignores its run bit; mode 3 or its shut gate still stops it
    assign inc_b = tick_r & (split_a | run_bit_b_r)
        & (~sel_b.gate | gate_pin_b)
        & (sel_b.mode != dtc_pkg::DTC_MODE_SPLIT)
        & (sel_b.ct ? fall_b : 1'b1); // [R13] [R16] [R6]
    // split high byte counts machine cycles under timer b's run bit
    assign inc_ha = tick_r & split_a & run_bit_b_r; // [R15]
    assign ha_sum = {1'b0, high_a_r} + 9'h001;

    assign step_a = step_f(sel_a.mode, low_a_r, high_a_r, inc_a);
    assign step_b = step_f(sel_b.mode, low_b_r, high_b_r, inc_b);
    assign ovf_a = step_a.ovf;
    assign ovf_b = step_b.ovf;
    assign set_fa = ovf_a; // [R8]
    // split high byte takes over flag b from timer b
    assign set_fb = split_a ? (inc_ha & ha_sum[8]) : ovf_b; // [R15]

    // apb decode; a write lands at the access edge with pready high
    assign setup = psel & ~penable;
    assign acc_wr = psel & penable & pready_r & pwrite;
    assign wr_tmode = acc_wr & (paddr == `DTC_OFF_TMODE);
    assign wr_ctl = acc_wr & (paddr == `DTC_OFF_TCTL);
    assign wr_low_a = acc_wr & (paddr == `DTC_OFF_LOW_A);
    assign wr_high_a = acc_wr & (paddr == `DTC_OFF_HIGH_A);
    assign wr_low_b = acc_wr & (paddr == `DTC_OFF_LOW_B);
    assign wr_high_b = acc_wr & (paddr == `DTC_OFF_HIGH_B);
    assign wr_pmode = acc_wr & (paddr == `DTC_OFF_PMODE);
    assign wr_cfg = acc_wr & (paddr == `DTC_OFF_CFG);

    // control register view, reserved bits read zero
    always_comb
    begin
        ctl_view = 8'h00;
        ctl_view[`DTC_CTL_RUN_A] = run_bit_a_r;
        ctl_view[`DTC_CTL_FLAG_A] = flag_a_r;
        ctl_view[`DTC_CTL_RUN_B] = run_bit_b_r;
        ctl_view[`DTC_CTL_FLAG_B] = flag_b_r;
    end

    // machine cycle divider; the halve setting only changes at a tick
    // so no machine cycle is ever cut short
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_r <= 4'h0;
            tick_r <= 1'b0;
            halve_eff_r <= 1'b0;
        end
        else if (div_r >= (halve_eff_r ? `DTC_MC_CLKS_HALVED - 4'h1
                                       : `DTC_MC_CLKS - 4'h1))
        begin
            div_r <= 4'h0;
            tick_r <= 1'b1; // [R1] [R19]
            halve_eff_r <= halve_r; // [R19]
        end
        else
        begin
            div_r <= div_r + 4'h1;
            tick_r <= 1'b0;
        end
    end

    // configuration registers written by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tmode_r <= `DTC_RST_BYTE;
            run_bit_a_r <= 1'b0;
            run_bit_b_r <= 1'b0;
            tog_en_a_r <= 1'b0;
            tog_en_b_r <= 1'b0;
            halve_r <= 1'b0;
        end
        else
        begin
            if (wr_tmode)
                tmode_r <= pwdata[7:0];
            // run bits touch no count register
            if (wr_ctl)
            begin
                run_bit_a_r <= pwdata[`DTC_CTL_RUN_A]; // [R9]
                run_bit_b_r <= pwdata[`DTC_CTL_RUN_B]; // [R9]
            end
            if (wr_pmode)
            begin
                tog_en_a_r <= pwdata[`DTC_PM_TOG_A]; // [R18]
                tog_en_b_r <= pwdata[`DTC_PM_TOG_B]; // [R18]
            end
            if (wr_cfg)
                halve_r <= pwdata[`DTC_CFG_HALVE]; // [R19]
        end
    end

    // overflow flags; an overflow in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_a_r <= 1'b0;
            flag_b_r <= 1'b0;
        end
        else
        begin
            if (set_fa)
                flag_a_r <= 1'b1; // [R8]
            else if (wr_ctl)
                flag_a_r <= pwdata[`DTC_CTL_FLAG_A]; // [R20]
            else if (irq_ack_a)
                flag_a_r <= 1'b0; // [R20]
            if (set_fb)
                flag_b_r <= 1'b1; // [R8] [R15]
            else if (wr_ctl)
                flag_b_r <= pwdata[`DTC_CTL_FLAG_B]; // [R20]
            else if (irq_ack_b)
                flag_b_r <= 1'b0; // [R20]
        end
    end

    // count bytes; a software write beats a count in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_a_r <= `DTC_RST_BYTE;
            high_a_r <= `DTC_RST_BYTE;
            low_b_r <= `DTC_RST_BYTE;
            high_b_r <= `DTC_RST_BYTE;
        end
        else
        begin
            low_a_r <= wr_low_a ? pwdata[7:0] : step_a.lo;
            if (wr_high_a)
                high_a_r <= pwdata[7:0];
            else if (split_a)
                high_a_r <= inc_ha ? ha_sum[7:0] : high_a_r; // [R15]
            else
                high_a_r <= step_a.hi;
            low_b_r <= wr_low_b ? pwdata[7:0] : step_b.lo;
            high_b_r <= wr_high_b ? pwdata[7:0] : step_b.hi;
        end
    end

    // toggle outputs rest high while disabled, flip on each overflow
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tog_a_r <= 1'b1;
            tog_b_r <= 1'b1;
            baud_r <= 1'b0;
        end
        else
        begin
            if (!tog_en_a_r)
                tog_a_r <= 1'b1; // [R18]
            else if (ovf_a)
                tog_a_r <= ~tog_a_r; // [R17]
            if (!tog_en_b_r)
                tog_b_r <= 1'b1; // [R18]
            else if (ovf_b)
                tog_b_r <= ~tog_b_r; // [R17]
            // timer b overflows stay visible even while a is split
            baud_r <= ovf_b; // [R16]
        end
    end

    // apb answer: data caught at setup, pready high in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup;
            if (setup)
            begin
                pslverr_r <= 1'b0;
                case (paddr)
                    `DTC_OFF_TMODE: prdata_r <= {24'h000000, tmode_r};
                    `DTC_OFF_TCTL: prdata_r <= {24'h000000, ctl_view};
                    `DTC_OFF_LOW_A: prdata_r <= {24'h000000, low_a_r};
                    `DTC_OFF_HIGH_A: prdata_r <= {24'h000000, high_a_r};
                    `DTC_OFF_LOW_B: prdata_r <= {24'h000000, low_b_r};
                    `DTC_OFF_HIGH_B: prdata_r <= {24'h000000, high_b_r};
                    `DTC_OFF_PMODE:
                        prdata_r <= {30'h00000000, tog_en_b_r, tog_en_a_r};
                    `DTC_OFF_CFG: prdata_r <= {31'h00000000, halve_r};
                    default:
                    begin
                        // unmapped: zero data and an error answer
                        prdata_r <= 32'h0000_0000;
                        pslverr_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // outputs straight from flip-flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign count_pin_a_drv = tog_a_r;
    assign count_pin_a_oe = tog_en_a_r; // [R17]
    assign count_pin_b_drv = tog_b_r;
    assign count_pin_b_oe = tog_en_b_r; // [R17]
    assign overflow_flag_a = flag_a_r;
    assign overflow_flag_b = flag_b_r;
    assign baud_tick = baud_r;

    // checks on the counting logic
    sequence seq_gap6;
        !tick_r [*5] ##1 tick_r;
    endsequence

    sequence seq_ovf_a_quiet;
        ovf_a && !acc_wr;
    endsequence

    a_tick_six_clk: assert property ( // [R1]
        tick_r && !halve_eff_r |=> seq_gap6)
        else $error("machine cycle is not six clocks");

    a_run_hold_low: assert property ( // [R6]
        tick_r && !run_bit_a_r && !acc_wr |=> $stable(low_a_r))
        else $error("timer a counted while stopped");

    a_flag_set_a: assert property ( // [R8]
        ovf_a |=> flag_a_r)
        else $error("overflow did not set flag a");

    a_wrap_thirteen: assert property ( // [R7]
        seq_ovf_a_quiet and sel_a.mode == dtc_pkg::DTC_MODE_13
        |=> high_a_r == 8'h00 && low_a_r[4:0] == 5'h00)
        else $error("thirteen bit wrap not to zero");

    a_reload_low: assert property ( // [R12]
        seq_ovf_a_quiet and sel_a.mode == dtc_pkg::DTC_MODE_RELOAD
        |=> low_a_r == $past(high_a_r) && $stable(high_a_r))
        else $error("reload did not copy high byte");

    a_b_mode3_stop: assert property ( // [R13]
        sel_b.mode == dtc_pkg::DTC_MODE_SPLIT && !acc_wr
        |=> $stable(low_b_r) && $stable(high_b_r))
        else $error("timer b counted in mode 3");

    a_split_high_flag: assert property ( // [R15]
        inc_ha && high_a_r == 8'hff |=> flag_b_r && high_a_r == 8'h00)
        else $error("split high byte overflow lost");

    a_toggle_flip_a: assert property ( // [R17]
        seq_ovf_a_quiet and tog_en_a_r
        |=> count_pin_a_drv != $past(count_pin_a_drv))
        else $error("toggle output a did not flip");

    a_flag_hold_a: assert property ( // [R20]
        flag_a_r && !wr_ctl && !irq_ack_a |=> flag_a_r)
        else $error("flag a dropped without a clear");

endmodule

/* File: dtc_consts.svh */
// register offsets, field positions, reset values and timing counts
// for the dual timer/counter block; included by the top design file and the bench
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// apb byte offsets, one aligned word per register
`define DTC_OFF_TMODE 8'h00
`define DTC_OFF_TCTL 8'h04
`define DTC_OFF_LOW_A 8'h08
`define DTC_OFF_HIGH_A 8'h0c
`define DTC_OFF_LOW_B 8'h10
`define DTC_OFF_HIGH_B 8'h14
`define DTC_OFF_PMODE 8'h18
`define DTC_OFF_CFG 8'h1c

// timer mode register fields
`define DTC_TMODE_A_LSB 0
`define DTC_TMODE_A_MSB 3
`define DTC_TMODE_B_LSB 4
`define DTC_TMODE_B_MSB 7

// timer control register bits
`define DTC_CTL_RUN_A 4
`define DTC_CTL_FLAG_A 5
`define DTC_CTL_RUN_B 6
`define DTC_CTL_FLAG_B 7

// port mode and configuration bits
`define DTC_PM_TOG_A 0
`define DTC_PM_TOG_B 1
`define DTC_CFG_HALVE 0

// reset values
`define DTC_RST_BYTE 8'h00

// clocks per machine cycle, default and halved
`define DTC_MC_CLKS 4'h6
`define DTC_MC_CLKS_HALVED 4'hc

`endif

/* File: dtc_pkg.sv */
// types shared by the dual timer/counter design files
// assumes dtc_consts.svh holds all numeric constants
package dtc_pkg;

    // operating mode of one timer
    typedef enum logic [1:0] {
        DTC_MODE_13,
        DTC_MODE_16,
        DTC_MODE_RELOAD,
        DTC_MODE_SPLIT
    } dtc_mode_t;

    // one nibble of the timer mode register
    typedef struct packed {
        logic gate;
        logic ct;
        dtc_mode_t mode;
    } dtc_tsel_t;

    // result of one counting step
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic ovf;
    } dtc_step_t;

endpackage

/* File: dtc_pin_sampler.sv */
// samples an external count pin once per machine cycle and flags a fall
// assumes the pin is synchronous to pclk and tick is a one-cycle pulse
module dtc_pin_sampler (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // machine cycle pulse
    input wire logic tick,
    // pin level
    input wire logic pin,
    // fall seen at the last tick, held until the next one
    output logic fall
);

    logic smp_r; // pin level at the last tick
    logic pend_r; // high-then-low seen, applied at the next tick

    // one sample per machine cycle; the fall is only acted on a machine
    // cycle later, so a pulse shorter than a machine cycle may be missed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            smp_r <= 1'b0;
            pend_r <= 1'b0;
        end
        else if (tick)
        begin
            smp_r <= pin;
            pend_r <= smp_r & ~pin; // [R2]
        end
    end

    assign fall = pend_r;

endmodule

/* File: dtc_pin_model.sv */
// partner model: the outside world on the two external count pins
// assumes the bench calls hold_level right after a rising pclk edge
module dtc_pin_model (
    // clock
    input wire logic pclk,
    // toggle outputs of the design
    input wire logic drv_a,
    input wire logic oe_a,
    input wire logic drv_b,
    input wire logic oe_b,
    // resolved pin levels seen by the design
    output logic pin_a,
    output logic pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lvl_a = 1'b1; // idle high, so no fall is seen out of reset
    logic lvl_b = 1'b1; // pin b is only ever a toggle output here
    // the design wins the wire while its toggle output is enabled
    assign pin_a = oe_a ? drv_a : lvl_a;
    assign pin_b = oe_b ? drv_b : lvl_b;
    // drive a level and keep it; the caller never asks for less than
    // one machine cycle, otherwise a level could slip between samples
    task automatic hold_level(input logic lvl, input int cycles);
        lvl_a <= lvl;
        repeat (cycles) @(posedge pclk);
    endtask
endmodule

/* File: dtc_timer_top_tb_top.sv */
// self-checking bench for the dual timer/counter block
// assumes dtc_consts.svh is on the include path; pclk is 250 MHz
`include "dtc_consts.svh"
module dtc_timer_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0; // bus clock
    logic presetn = 1'b0; // held low for the first ten edges
    logic psel = 1'b0; // apb request lines
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata; // apb answer
    logic pready;
    logic pslverr;
    logic pin_a, pin_b, drv_a, oe_a, drv_b, oe_b; // count pin wiring
    logic gate_a = 1'b0; // gate pins
    logic gate_b = 1'b0;
    logic ack_a = 1'b0; // interrupt acknowledge pulses
    logic ack_b = 1'b0;
    logic flag_a, flag_b, baud; // flags towards the chip
    logic [33:0] notes[$]; // {check data, expected error, expected data}
    logic [33:0] note; // oldest note, taken by the monitor
    logic [31:0] seed = 32'hfd4447cc; // fixed start of the random stream
    int num_errors = 0;
    int n_tests = 0;
    int n_baud = 0; // baud pulses seen since reset
    int i;

    // 4 ns period
    always #2 pclk = ~pclk;

    dtc_timer_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_pin_a(pin_a), .count_pin_a_drv(drv_a), .count_pin_a_oe(oe_a),
        .count_pin_b(pin_b), .count_pin_b_drv(drv_b), .count_pin_b_oe(oe_b),
        .gate_pin_a(gate_a), .gate_pin_b(gate_b), .irq_ack_a(ack_a),
        .irq_ack_b(ack_b), .overflow_flag_a(flag_a),
        .overflow_flag_b(flag_b), .baud_tick(baud));

    dtc_pin_model u_pins (.pclk(pclk), .drv_a(drv_a), .oe_a(oe_a),
        .drv_b(drv_b), .oe_b(oe_b), .pin_a(pin_a), .pin_b(pin_b));

    // xorshift stream, reproducible from the fixed seed
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // verdict and end of run, the single exit point
    task automatic results();
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // a wait that ran out counts as a mismatch and ends the run
    task automatic timeout();
        num_errors++;
        results();
    endtask

    // bus word comparison
    task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    // single pin or flag comparison
    task automatic cmp_pin(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    // one apb transfer; the expected answer is noted for the monitor
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic chk, input logic err);
        int k;
        k = 0;
        @(posedge pclk);
        notes.push_back({chk, err, d});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // request held until pready is seen high at a rising edge
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1)
            timeout();
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        bus(1'b0, a, {24'h0, d}, 1'b1, 1'b0);
    endtask

    // bounded wait for an overflow flag; flag b when sel is high
    task automatic wait_flag(input logic sel, input int lim);
        int k;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while ((sel ? flag_b : flag_a) !== 1'b1 && k < lim);
        if ((sel ? flag_b : flag_a) !== 1'b1)
            timeout();
    endtask

    // monitor: every completed transfer is checked against the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && notes.size() > 0)
        begin
            note = notes.pop_front();
            cmp_pin(pslverr, note[32]);
            if (note[33])
                cmp_bus(prdata, note[31:0]);
        end
    end

    // baud pulse counter; an unknown level counts too, so it cannot hide
    always @(posedge pclk)
    begin
        if (presetn && baud !== 1'b0)
            n_baud++;
    end

    // main sequence
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset state, then refused accesses outside the map
        for (i = 0; i < 8; i++)
            rd(8'(i * 4), 8'h00);
        bus(1'b0, 8'h20, 32'h0, 1'b1, 1'b1);
        bus(1'b1, 8'h24, 32'hff, 1'b0, 1'b1);
        @(negedge pclk);
        cmp_pin(oe_a, 1'b0);
        cmp_pin(drv_a, 1'b1);
        cmp_pin(oe_b, 1'b0);
        cmp_pin(drv_b, 1'b1);
        // counter on pin a in mode 1, five falls with random holds
        wr(`DTC_OFF_TMODE, 8'h05);
        rd(`DTC_OFF_TMODE, 8'h05);
        wr(`DTC_OFF_TCTL, 8'h10);
        for (i = 0; i < 5; i++)
        begin
            u_pins.hold_level(1'b0, 7 + int'(rnd() % 5));
            u_pins.hold_level(1'b1, 7 + int'(rnd() % 5));
        end
        wr(`DTC_OFF_TCTL, 8'h00);
        rd(`DTC_OFF_LOW_A, 8'h05);
        // both gated; gate a open, gate b shut; window of exact ticks
        gate_a <= 1'b1;
        for (i = 0; i < 2; i++)
        begin
            wr(`DTC_OFF_CFG, 8'(i));
            wr(`DTC_OFF_TMODE, 8'h99);
            wr(`DTC_OFF_LOW_A, 8'h03);
            wr(`DTC_OFF_LOW_B, 8'h07);
            wr(`DTC_OFF_TCTL, 8'h50);
            // run and stop writes land 60 or 120 clocks apart: 10 ticks
            repeat (57 + 60 * i) @(posedge pclk);
            wr(`DTC_OFF_TCTL, 8'h00);
            rd(`DTC_OFF_LOW_A, 8'h0d);
            rd(`DTC_OFF_LOW_B, 8'h07);
        end
        wr(`DTC_OFF_CFG, 8'h00);
        // auto-reload on timer a with its toggle output enabled
        wr(`DTC_OFF_PMODE, 8'h01);
        @(negedge pclk);
        cmp_pin(oe_a, 1'b1);
        cmp_pin(drv_a, 1'b1);
        wr(`DTC_OFF_TMODE, 8'h02);
        wr(`DTC_OFF_HIGH_A, 8'hfd);
        wr(`DTC_OFF_LOW_A, 8'hf0 | 8'(rnd() % 16));
        wr(`DTC_OFF_TCTL, 8'h10);
        wait_flag(1'b0, 200);
        rd(`DTC_OFF_LOW_A, 8'hfd);
        @(negedge pclk);
        cmp_pin(drv_a, 1'b0);
        @(posedge pclk);
        ack_a <= 1'b1;
        @(posedge pclk);
        ack_a <= 1'b0;
        @(negedge pclk);
        cmp_pin(flag_a, 1'b0);
        wr(`DTC_OFF_TCTL, 8'h00);
        // split timer a, timer b parked in mode 3
        wr(`DTC_OFF_PMODE, 8'h00);
        wr(`DTC_OFF_TMODE, 8'h33);
        wr(`DTC_OFF_LOW_B, 8'h55);
        wr(`DTC_OFF_HIGH_A, 8'hff);
        wr(`DTC_OFF_TCTL, 8'h40);
        wait_flag(1'b1, 40);
        rd(`DTC_OFF_TCTL, 8'hc0);
        rd(`DTC_OFF_LOW_B, 8'h55);
        // b leaves mode 3 while a is split: it runs, flag b stays clear
        wr(`DTC_OFF_TCTL, 8'h40);
        wr(`DTC_OFF_TMODE, 8'h23);
        wr(`DTC_OFF_LOW_B, 8'hff);
        repeat (12) @(posedge pclk);
        rd(`DTC_OFF_TCTL, 8'h40);
        cmp_bus(n_baud, 32'h1);
        // thirteen-bit timer b; upper low-byte bits keep their value
        wr(`DTC_OFF_TCTL, 8'h00);
        wr(`DTC_OFF_TMODE, 8'h00);
        wr(`DTC_OFF_LOW_B, 8'hfe);
        wr(`DTC_OFF_HIGH_B, 8'hff);
        wr(`DTC_OFF_TCTL, 8'h40);
        wait_flag(1'b1, 40);
        rd(`DTC_OFF_LOW_B, 8'he0);
        rd(`DTC_OFF_HIGH_B, 8'h00);
        cmp_bus(n_baud, 32'h2);
        ack_b <= 1'b1;
        @(posedge pclk);
        ack_b <= 1'b0;
        @(negedge pclk);
        cmp_pin(flag_b, 1'b0);
        results();
    end
endmodule
